/* File: core/acdp_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acdp_regs.svh"
module acdp_ctrl
	import acdp_pkg::*;
#(
	parameter int WAKE_CYC  = `ACDP_WAKE_CYC,
	parameter int DEPTH     = `ACDP_BUF_DEPTH
)
(
	input  wire logic                  ref_clk,                 // System clock
	input  wire logic                  rstn,                    // Async reset
	input  wire logic                  clk_en,                  // Clock enable
	input  wire logic                  rx_select,               // Receive select
	input  wire logic                  tx_select,               // Transmit select
	input  wire logic                  conv_clk,                // Converter clock
	input  wire logic                  tx_sample_msb,           // Sample bit 6
	input  wire logic                  tx_sample_bit_below_msb, // Sample bit 5
	input  wire logic [4:0]            shared_data_in,          // Shared lines in
	output logic      [4:0]            shared_data_out,         // Shared lines out
	output logic      [4:0]            shared_data_oe,          // Shared drive en
	input  wire logic [`ACDP_ADC_W-1:0] adc_code_in,            // ADC core result
	output logic                       adc_sample_strobe,       // ADC sampled
	input  wire logic                  dac_ready,               // DAC core ready
	output acdp_tx_word_s              dac_code,                // DAC core code
	output logic                       dac_strobe,              // DAC updated
	output logic                       tx_buf_ready,            // Buffer has room
	output logic                       tx_overrun,              // Sample dropped
	output logic                       adc_enable,              // ADC powered
	output logic                       dac_enable,              // DAC powered
	output logic                       conv_ready               // Wake-up done
);
	localparam int CNT_W = $clog2(WAKE_CYC + 1);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int OCC_W = $clog2(DEPTH + 1);

	// ****************************************
	// Decoding
	// ****************************************
	function automatic acdp_mode_e decode_mode(input logic rx, input logic tx);
		acdp_mode_e m;
		m = ACDP_SHUTDOWN;
		if (rx && !tx)
			m = ACDP_RECEIVE;
		else if (tx && !rx)
			m = ACDP_TRANSMIT;
		return m;
	endfunction

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		logic [PTR_W-1:0] r;
		r = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
		return r;
	endfunction

	// ****************************************
	// Mode and wake-up
	// ****************************************
	acdp_mode_e       mode, next_mode;
	logic [CNT_W-1:0] wake_cnt, next_wake_cnt;
	logic             conv_q, next_conv_q;
	logic             next_adc_enable, next_dac_enable, next_conv_ready;
	logic             fall_edge, rise_edge, rx_active, tx_active;

	// Inputs are synchronous, so a one-flop history finds the edges
	assign fall_edge = conv_q && !conv_clk;
	assign rise_edge = !conv_q && conv_clk;
	assign rx_active = (mode == ACDP_RECEIVE) && conv_ready;
	assign tx_active = (mode == ACDP_TRANSMIT) && conv_ready;

	always_comb
	begin
		next_mode       = decode_mode(rx_select, tx_select);
		next_adc_enable = (next_mode == ACDP_RECEIVE);
		next_dac_enable = (next_mode == ACDP_TRANSMIT);
		next_conv_q     = conv_clk;
		next_wake_cnt   = wake_cnt;
		next_conv_ready = conv_ready;
		// wake-up count, restarted by every shutdown
		if (next_mode == ACDP_SHUTDOWN)
		begin
			next_wake_cnt   = '0;
			next_conv_ready = 1'b0;
		end
		else if (!conv_ready)
		begin
			next_wake_cnt   = wake_cnt + CNT_W'(1);
			next_conv_ready = (wake_cnt == CNT_W'(WAKE_CYC - 1));
		end
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mode       <= ACDP_SHUTDOWN;
			wake_cnt   <= '0;
			conv_q     <= 1'b0;
			adc_enable <= 1'b0;
			dac_enable <= 1'b0;
			conv_ready <= 1'b0;
		end
		else if (clk_en)
		begin
			mode       <= next_mode;
			wake_cnt   <= next_wake_cnt;
			conv_q     <= next_conv_q;
			adc_enable <= next_adc_enable;
			dac_enable <= next_dac_enable;
			conv_ready <= next_conv_ready;
		end
	end

	// ****************************************
	// Receive path
	// ****************************************
	logic [4:0] rx_sample, next_rx_sample;
	logic [4:0] next_shared_out, next_shared_oe;
	logic       next_adc_strobe;

	always_comb
	begin
		next_rx_sample  = rx_sample;
		next_shared_out = shared_data_out;
		next_adc_strobe = 1'b0;
		next_shared_oe  = {5{next_mode == ACDP_RECEIVE}};
		if (rx_active && fall_edge)
		begin
			next_rx_sample  = adc_code_in;
			next_adc_strobe = 1'b1;
		end
		// result onto lines at rising edge
		if (rx_active && rise_edge)
			next_shared_out = rx_sample;
		if (next_mode != ACDP_RECEIVE)
			next_shared_out = `ACDP_SHARED_RST;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rx_sample         <= `ACDP_SHARED_RST;
			shared_data_out   <= `ACDP_SHARED_RST;
			shared_data_oe    <= 5'h00;
			adc_sample_strobe <= 1'b0;
		end
		else if (clk_en)
		begin
			rx_sample         <= next_rx_sample;
			shared_data_out   <= next_shared_out;
			shared_data_oe    <= next_shared_oe;
			adc_sample_strobe <= next_adc_strobe;
		end
	end

	// ****************************************
	// Transmit buffer
	// ****************************************
	acdp_tx_word_s    tx_mem [DEPTH];
	acdp_tx_word_s    next_mem [DEPTH];
	acdp_tx_word_s    tx_word, next_dac_code;
	logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [OCC_W-1:0] occ, next_occ;
	logic             tx_push, tx_pop, next_dac_strobe, next_overrun;

	assign tx_word = '{msb: tx_sample_msb, below_msb: tx_sample_bit_below_msb,
		lower: shared_data_in};
	// capture on fall, update on rise
	assign tx_push = tx_active && fall_edge && (occ != OCC_W'(DEPTH));
	assign tx_pop  = tx_active && rise_edge && dac_ready && (occ != '0);

	always_comb
	begin
		next_mem        = tx_mem;
		next_wr_ptr     = wr_ptr;
		next_rd_ptr     = rd_ptr;
		next_occ        = occ;
		next_dac_code   = dac_code;
		next_dac_strobe = 1'b0;
		// Full buffer drops the word rather than overwrite a queued one
		next_overrun    = tx_active && fall_edge && (occ == OCC_W'(DEPTH));
		if (tx_push)
		begin
			next_mem[wr_ptr] = tx_word;
			next_wr_ptr      = ptr_inc(wr_ptr);
		end
		if (tx_pop)
		begin
			next_dac_code   = tx_mem[rd_ptr];
			next_dac_strobe = 1'b1;
			next_rd_ptr     = ptr_inc(rd_ptr);
		end
		next_occ = occ + OCC_W'(tx_push) - OCC_W'(tx_pop);
		// Stale samples must not leak into the next burst
		if (next_mode != ACDP_TRANSMIT)
		begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_occ    = '0;
		end
	end

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++)
		begin : g_mem
			always_ff @(posedge ref_clk or negedge rstn)
			begin
				if (!rstn)
					tx_mem[g] <= `ACDP_DAC_RST;
				else if (clk_en)
					tx_mem[g] <= next_mem[g];
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_ptr       <= '0;
			rd_ptr       <= '0;
			occ          <= '0;
			dac_code     <= `ACDP_DAC_RST;
			dac_strobe   <= 1'b0;
			tx_overrun   <= 1'b0;
			tx_buf_ready <= 1'b0;
		end
		else if (clk_en)
		begin
			wr_ptr       <= next_wr_ptr;
			rd_ptr       <= next_rd_ptr;
			occ          <= next_occ;
			dac_code     <= next_dac_code;
			dac_strobe   <= next_dac_strobe;
			tx_overrun   <= next_overrun;
			tx_buf_ready <= (next_occ != OCC_W'(DEPTH));
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk iff clk_en);
	endclocking
	default disable iff (!rstn);

	a_rx_mode_enable: assert property (rx_select && !tx_select |=> adc_enable && !dac_enable)
		else $error("receive mode did not enable ADC only");
	a_tx_mode_enable: assert property (tx_select && !rx_select |=> dac_enable && !adc_enable)
		else $error("transmit mode did not enable DAC only");
	a_shutdown_both_off: assert property ((rx_select == tx_select) |=> !adc_enable && !dac_enable && mode == decode_mode(1'b0, 1'b0))
		else $error("shutdown left a converter on");
	a_tx_bit_order: assert property (tx_push |=> tx_mem[$past(wr_ptr)] == $past(tx_word) && tx_mem[$past(wr_ptr)].msb == $past(tx_sample_msb))
		else $error("transmit sample bits misplaced");
	a_rx_drive_out: assert property (rx_active && rise_edge && next_mode == ACDP_RECEIVE |=> shared_data_out == $past(rx_sample) && shared_data_oe == 5'h1F)
		else $error("receive result not driven on rise");
	a_rx_sample_fall: assert property (rx_active && fall_edge |=> adc_sample_strobe && rx_sample == $past(adc_code_in))
		else $error("ADC not sampled on falling edge");
	a_dac_update_rise: assert property (tx_pop |=> dac_strobe && dac_code == $past(tx_mem[rd_ptr]) && $past(conv_clk) && !$past(conv_q))
		else $error("DAC not updated on rising edge");
	a_shutdown_quiet: assert property (mode == ACDP_SHUTDOWN ##1 mode == ACDP_SHUTDOWN |-> !adc_sample_strobe && !dac_strobe && shared_data_oe == 5'h00)
		else $error("activity while shut down");
	a_wake_time: assert property ($rose(conv_ready) |-> $past(wake_cnt) == CNT_W'(WAKE_CYC - 1) && mode != ACDP_SHUTDOWN)
		else $error("ready before wake-up time");
	a_lines_released: assert property (mode != ACDP_RECEIVE |-> shared_data_oe == 5'h00 && shared_data_out == 5'h00)
		else $error("shared lines driven outside receive");

	c_rx_convert: cover property (rx_active && fall_edge ##[1:20] rx_active && rise_edge);
	c_tx_update:  cover property (tx_push ##[1:20] tx_pop);
	c_buf_full:   cover property (tx_active && !tx_buf_ready);
	c_wake_done:  cover property ($rose(conv_ready));
endmodule
`default_nettype wire

/* File: core/acdp_regs.svh */
`ifndef ACDP_REGS_SVH
`define ACDP_REGS_SVH
// ****************************************
// Timing and widths
// ****************************************
`define ACDP_CLK_NS       20
`define ACDP_WAKE_NS      2400
`define ACDP_WAKE_CYC     ((`ACDP_WAKE_NS + `ACDP_CLK_NS - 1) / `ACDP_CLK_NS)
`define ACDP_ADC_W        5
`define ACDP_BUF_DEPTH    2
`define ACDP_SHARED_RST   5'h00
`define ACDP_DAC_RST      7'h00
`endif

/* File: core/acdp_pkg.sv */
`default_nettype none
package acdp_pkg;
	typedef enum logic [1:0] {ACDP_SHUTDOWN, ACDP_TRANSMIT, ACDP_RECEIVE}
		acdp_mode_e;
	// Transmit sample, two's complement, MSB first
	typedef struct packed
	{
		logic       msb;
		logic       below_msb;
		logic [4:0] lower;
	} acdp_tx_word_s;
endpackage
`default_nettype wire

/* File: bench/acdp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module acdp_host_model
	import acdp_pkg::*;
(
	input  wire logic           ref_clk,  // System clock
	input  wire logic           tx_mode,  // Controller transmits
	input  wire logic           release_n,// Low: lines show the inverse word
	output var logic            conv_clk, // Converter clock
	output var acdp_tx_word_s   word,     // Sample on the pins
	output var logic [4:0]      lines     // Host side of shared lines
);
	int            ph = 0;
	int            seed = 32'h4251;
	logic          clk_r = 1'b0;
	acdp_tx_word_s word_r = '0;
	assign conv_clk = clk_r;
	assign word     = word_r;
	always @(negedge ref_clk)
	begin
		ph = (ph + 1) % 3;
		if (ph == 0)
		begin
			clk_r <= ~clk_r;
			// new word on rise, zero unless sending
			if (!clk_r)
				word_r <= tx_mode ? 7'($random(seed)) : 7'h00;
		end
	end
	// lines low at once in shutdown; unreleased lines (release_n low) show the inverse
	assign lines = !release_n ? ~word_r.lower
		: (tx_mode ? word_r.lower : 5'h00);
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import acdp_pkg::*;
;
	logic ref_clk = 1'b0, rstn = 1'b0, rx_select = 1'b0, tx_select = 1'b0;
	logic dac_ready = 1'b0, clk_en = 1'b1, conv_clk, adc_sample_strobe;
	logic dac_strobe;
	logic tx_buf_ready, tx_overrun, adc_enable, dac_enable, conv_ready;
	logic [4:0] adc_code_in = 5'h00, shared_data_in, shared_data_out;
	logic [4:0] shared_data_oe, lines, exp5;
	acdp_tx_word_s word, dac_code, pend;
	acdp_tx_word_s q[$];
	int n_mismatch = 0, samples_checked = 0, seed = 32'h4251;
	int n_ovr = 0, n_dac = 0, n_smp = 0;
	logic conv_h = 1'b0, pv = 1'b0;
	always #10 ref_clk = ~ref_clk;
	assign shared_data_in = (shared_data_oe & shared_data_out)
		| (~shared_data_oe & lines);
	acdp_host_model host_u (.ref_clk(ref_clk), .tx_mode(tx_select & !rx_select),
		.release_n(!(rx_select & !tx_select)), .conv_clk(conv_clk),
		.word(word), .lines(lines));
	acdp_ctrl #(.WAKE_CYC(4)) dut_u (.ref_clk(ref_clk), .rstn(rstn),
		.clk_en(clk_en), .rx_select(rx_select), .tx_select(tx_select),
		.conv_clk(conv_clk), .tx_sample_msb(word.msb),
		.tx_sample_bit_below_msb(word.below_msb),
		.shared_data_in(shared_data_in), .shared_data_out(shared_data_out),
		.shared_data_oe(shared_data_oe), .adc_code_in(adc_code_in),
		.adc_sample_strobe(adc_sample_strobe), .dac_ready(dac_ready),
		.dac_code(dac_code), .dac_strobe(dac_strobe),
		.tx_buf_ready(tx_buf_ready), .tx_overrun(tx_overrun),
		.adc_enable(adc_enable), .dac_enable(dac_enable),
		.conv_ready(conv_ready));
	task automatic chk(input bit ok, input string msg);
		samples_checked++;
		if (!ok)
		begin
			n_mismatch++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wait_lvl(input logic v);
		int k;
		for (k = 0; k < 20 && conv_clk !== v; k++)
			@(negedge ref_clk);
		if (conv_clk !== v)
		begin
			chk(1'b0, "converter clock stuck");
			report_and_stop();
		end
	endtask
	// Expected DAC words, rebuilt from the pins at each seen fall
	always @(posedge ref_clk)
	begin
		conv_h <= conv_clk;
		pv <= conv_h && !conv_clk && dac_enable === 1'b1 && conv_ready === 1'b1;
		pend <= {word.msb, word.below_msb, shared_data_in};
		n_ovr <= n_ovr + (tx_overrun === 1'b1);
		n_smp <= n_smp + (adc_sample_strobe === 1'b1);
		if (pv && tx_overrun !== 1'b1)
			q.push_back(pend);
		if (dac_strobe === 1'b1)
		begin
			n_dac <= n_dac + 1;
			chk(q.size() > 0 && dac_code === q.pop_front(), "dac word");
		end
		// Last pop may land on the edge that leaves transmit
		if (dac_enable !== 1'b1)
			q.delete();
	end
	initial
	begin
		repeat (10) @(negedge ref_clk);
		chk(adc_enable === 1'b0 && shared_data_oe === 5'h00, "reset outputs");
		rstn = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			{rx_select, tx_select} = 2'(i);
			repeat (2) @(negedge ref_clk);
			chk(adc_enable === (i == 2) && dac_enable === (i == 1), "mode");
			chk(shared_data_oe === (i == 2 ? 5'h1F : 5'h00), "drive");
		end
		{rx_select, tx_select} = 2'b10;
		repeat (2) @(negedge ref_clk);
		chk(conv_ready === 1'b0 && adc_enable === 1'b1, "early ready");
		repeat (5) @(negedge ref_clk);
		chk(conv_ready === 1'b1, "wake-up");
		for (int i = 0; i < 8; i++)
		begin
			wait_lvl(1'b0);
			wait_lvl(1'b1);
			adc_code_in = (i < 2) ? (i ? 5'h10 : 5'h0F) : 5'($random(seed));
			exp5 = adc_code_in;
			wait_lvl(1'b0);
			wait_lvl(1'b1);
			repeat (3) @(negedge ref_clk);
			chk(shared_data_out === exp5, "receive data");
		end
		chk(n_smp > 7, "sample strobes");
		{rx_select, tx_select} = 2'b01;
		repeat (30) @(negedge ref_clk);
		chk(tx_buf_ready === 1'b0 && n_ovr > 0, "full buffer");
		for (int i = 0; i < 600; i++)
		begin
			dac_ready = 1'($random(seed));
			@(negedge ref_clk);
		end
		chk(n_dac > 20 && q.size() < 3, "transmit flow");
		dac_ready = 1'b0;
		repeat (2) @(negedge ref_clk);
		// Frozen block must ignore the shutdown request
		clk_en = 1'b0;
		{rx_select, tx_select} = 2'b11;
		repeat (3) @(negedge ref_clk);
		chk(dac_enable === 1'b1 && conv_ready === 1'b1, "freeze");
		clk_en = 1'b1;
		repeat (3) @(negedge ref_clk);
		chk(dac_enable === 1'b0 && conv_ready === 1'b0, "shutdown");
		chk(shared_data_oe === 5'h00, "lines released");
		report_and_stop();
	end
endmodule
`default_nettype wire
